// ---- pwrseq_pkg.sv ----
// Shared constants for the WLAN/Bluetooth power-up sequencer ends
package pwrseq_pkg;

  // ----------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 50_000_000;
  localparam int CYCLES_PER_MS = CLOCK_HZ / 1000;
  localparam int TIMER_W = 32;

  // Conversion used by every delay below; whole milliseconds are exact
  function automatic int ms_to_cycles(input int ms);
    return ms * CYCLES_PER_MS;
  endfunction

  // ----------------------------------------------------------------
  // Sequencing times in milliseconds and their cycle counts
  // ----------------------------------------------------------------
  localparam int DISCHARGE_MS = 100;
  localparam int POR_MAX_MS = 110;
  localparam int F0_DELAY_MS = 4;
  localparam int REFCLK_MS = 8;
  localparam int BT_BOOT_MS = 100;
  localparam int DEBOUNCE_MS = 100;
  localparam int BUS_RESET_MS = 10;
  localparam int SOF_GAP_MS = 10;
  localparam int POLL_GAP_MS = 1;
  localparam int DISCHARGE_CYCLES = ms_to_cycles(DISCHARGE_MS);
  localparam int POR_CYCLES = ms_to_cycles(POR_MAX_MS);
  localparam int F0_DELAY_CYCLES = ms_to_cycles(F0_DELAY_MS);
  localparam int REFCLK_CYCLES = ms_to_cycles(REFCLK_MS);
  localparam int BT_BOOT_CYCLES = ms_to_cycles(BT_BOOT_MS);
  // Strictly longer than the printed figure, hence one extra cycle
  localparam int DEBOUNCE_CYCLES = ms_to_cycles(DEBOUNCE_MS) + 1;
  localparam int BUS_RESET_CYCLES = ms_to_cycles(BUS_RESET_MS) + 1;
  localparam int SOF_GAP_CYCLES = ms_to_cycles(SOF_GAP_MS) + 1;
  localparam int POLL_GAP_CYCLES = ms_to_cycles(POLL_GAP_MS);

  // ----------------------------------------------------------------
  // Function-zero space
  // ----------------------------------------------------------------
  localparam int F0_ADDR_W = 8;
  localparam int F0_DATA_W = 8;
  localparam logic [7:0] F0_READY_ADDR = 8'h14;
  localparam logic [7:0] F0_PLL_ADDR = 8'h20;
  localparam logic [7:0] F0_STATE_ADDR = 8'h21;
  localparam logic [7:0] READY_PATTERN_DEFAULT = 8'ha5;
  localparam int WAKE_BIT_DEFAULT = 0;
  localparam int F0_ST_WAKE = 0;
  localparam int F0_ST_REFCLK = 1;
  localparam int F0_ST_PLL = 2;
  localparam int F0_ST_ACTIVE = 3;

  // ----------------------------------------------------------------
  // Host controller registers (Avalon word addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_CTRL = 2'h0;
  localparam logic [1:0] REG_XTAL = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [1:0] REG_MASK = 2'h3;
  localparam int CTRL_WLAN_ON = 0;
  localparam int CTRL_BT_ON = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [7:0] XTAL_RESET = 8'h00;
  localparam int EVENT_W = 3;
  localparam int EV_WLAN_ACTIVE = 0;
  localparam int EV_BT_READY = 1;
  localparam int EV_PATTERN_SEEN = 2;
  localparam logic [2:0] MASK_RESET = 3'h0;
  localparam int STAT_WLAN_LIVE = 8;
  localparam int STAT_BT_LIVE = 9;
  localparam int STAT_DISCHARGE = 10;

endpackage

// ---- pwrseq_if.sv ----
// Link between the host sequencer and the WLAN/Bluetooth device
`timescale 1ns/1ns
`default_nettype none
interface pwrseq_if;
  import pwrseq_pkg::*;
  logic wlan_power_request;
  logic bt_power_request;
  logic f0_req;
  logic f0_write;
  logic [F0_ADDR_W-1:0] f0_addr;
  logic [F0_DATA_W-1:0] f0_wdata;
  logic f0_ack;
  logic [F0_DATA_W-1:0] f0_rdata;
  logic chip_active_irq;
  logic usb_dp_pullup;
  logic usb_bus_reset;
  logic usb_sof;

  modport device_end (
    input wlan_power_request, bt_power_request, f0_req, f0_write, f0_addr, f0_wdata,
    input usb_bus_reset, usb_sof,
    output f0_ack, f0_rdata, chip_active_irq, usb_dp_pullup
  );
  modport host_end (
    output wlan_power_request, bt_power_request, f0_req, f0_write, f0_addr, f0_wdata,
    output usb_bus_reset, usb_sof,
    input f0_ack, f0_rdata, chip_active_irq, usb_dp_pullup
  );
endinterface // pwrseq_if
`default_nettype wire

// ---- delay_timer.sv ----
// One-shot cycle timer: loaded by a start pulse, pulses done on expiry
`timescale 1ns/1ns
`default_nettype none
module delay_timer import pwrseq_pkg::*; #(
  parameter int WIDTH = TIMER_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [WIDTH-1:0] cycles,
  output logic running,
  output logic done
);
  logic [WIDTH-1:0] count;

  // A start while running reloads, so restarts never stack
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      count <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        count <= cycles;
        running <= 1'b1;
      end else if (running) begin
        if (count <= WIDTH'(1)) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - WIDTH'(1);
        end
      end
    end
  end
endmodule // delay_timer
`default_nettype wire

// ---- wlan_bt_device.sv ----
// Device end: regulator, reset, function-zero and USB attach sequencing
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - WLAN request high: regulators on, WLAN out of reset
// - WLAN request low holds WLAN in reset
// - Regulators enabled by OR of both requests
// - Bluetooth request low keeps Bluetooth in reset
// - Host waits 100 ms after both requests low
// - Internal reset held at most 110 ms
// - Host may lengthen any sequencing delay
// - Answer function-zero 0x14 after fixed delay
// - Host polls 0x14 until ready pattern
// - Host sets wake bit, waits 8 ms
// - Wake requests reference clock; PLL after 8 ms
// - Host writes PLL with crystal setting
// - Chip-active interrupt only after PLL lock
// - Bluetooth boots 100-250 ms, then D+ pull-up
// - Host debounces attach over 100 ms
// - Host drives USB bus reset over 10 ms
// - Host sends start-of-frame, interval over 10 ms
// - After start-of-frame Bluetooth ready for traffic
module wlan_bt_device import pwrseq_pkg::*; #(
  parameter int POR_HOLD_CYCLES = POR_CYCLES,
  parameter int F0_WAIT_CYCLES = F0_DELAY_CYCLES,
  parameter int REF_WAIT_CYCLES = REFCLK_CYCLES,
  parameter int BOOT_CYCLES = BT_BOOT_CYCLES,
  parameter logic [F0_DATA_W-1:0] READY_PATTERN = READY_PATTERN_DEFAULT,
  parameter int WAKE_BIT = WAKE_BIT_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_n,
  pwrseq_if.device_end link,
  input wire logic core_supply_good,
  input wire logic io_supply_good,
  input wire logic pll_lock,
  output logic regulator_enable,
  output logic wlan_reset_n,
  output logic bt_reset_n,
  output logic por_active,
  output logic ref_clock_request,
  output logic [F0_DATA_W-1:0] pll_setting,
  output logic bt_link_ready
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] core_sync;
  logic [1:0] io_sync;
  logic [1:0] lock_sync;

  // Supply monitors and lock come from analog, so two flops each
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      core_sync <= 2'b00;
      io_sync <= 2'b00;
      lock_sync <= 2'b00;
    end else begin
      core_sync <= {core_sync[0], core_supply_good};
      io_sync <= {io_sync[0], io_supply_good};
      lock_sync <= {lock_sync[0], pll_lock};
    end
  end

  wire supplies_good = core_sync[1] & io_sync[1];
  wire pll_locked = lock_sync[1];

  // ----------------------------------------------------------------
  // Internal power-on reset
  // ----------------------------------------------------------------
  logic supplies_prev;
  logic por_done;
  logic por_expired;

  // Count starts once both rails pass threshold; ends within the limit
  wire por_start = supplies_good & ~supplies_prev;
  wire next_por_done = supplies_good & (por_done | por_expired);

  delay_timer u_por_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(por_start),
    .cycles(TIMER_W'(POR_HOLD_CYCLES)),
    .running(),
    .done(por_expired)
  );

  // ----------------------------------------------------------------
  // Regulator and section resets
  // ----------------------------------------------------------------
  wire any_request = link.wlan_power_request | link.bt_power_request;
  wire next_wlan_on = link.wlan_power_request & por_done;
  wire next_bt_on = link.bt_power_request & por_done;
  wire wlan_rise = next_wlan_on & ~wlan_reset_n;
  wire bt_rise = next_bt_on & ~bt_reset_n;

  // Regulators follow the OR; each section follows only its own request
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      supplies_prev <= 1'b0;
      por_done <= 1'b0;
      por_active <= 1'b1;
      regulator_enable <= 1'b0;
      wlan_reset_n <= 1'b0;
      bt_reset_n <= 1'b0;
    end else begin
      supplies_prev <= supplies_good;
      por_done <= next_por_done;
      por_active <= ~next_por_done;
      regulator_enable <= any_request;
      wlan_reset_n <= next_wlan_on;
      bt_reset_n <= next_bt_on;
    end
  end

  // ----------------------------------------------------------------
  // Function-zero space and WLAN bring-up
  // ----------------------------------------------------------------
  logic f0_ready;
  logic f0_delay_done;
  logic refclk_valid;
  logic refclk_done;
  logic pll_programmed;

  // Accesses are answered only while the WLAN section is out of reset
  wire f0_take = link.f0_req & ~link.f0_ack & wlan_reset_n;
  wire f0_wr = f0_take & link.f0_write;
  wire at_ready = link.f0_addr == F0_READY_ADDR;
  wire at_pll = link.f0_addr == F0_PLL_ADDR;
  wire at_state = link.f0_addr == F0_STATE_ADDR;
  wire wake_write = f0_wr & at_ready & f0_ready & link.f0_wdata[WAKE_BIT];
  wire refclk_start = wake_write & ~ref_clock_request;
  wire pll_write = f0_wr & at_pll & refclk_valid;

  delay_timer u_f0_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(wlan_rise),
    .cycles(TIMER_W'(F0_WAIT_CYCLES)),
    .running(),
    .done(f0_delay_done)
  );

  delay_timer u_ref_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(refclk_start),
    .cycles(TIMER_W'(REF_WAIT_CYCLES)),
    .running(),
    .done(refclk_done)
  );

  // Read view: pattern only once ready, PLL only once the clock is valid
  wire [F0_DATA_W-1:0] state_view = F0_DATA_W'({link.chip_active_irq, pll_programmed,
                                                refclk_valid, ref_clock_request});
  wire [F0_DATA_W-1:0] ready_view = f0_ready ? READY_PATTERN : '0;
  wire [F0_DATA_W-1:0] pll_view = refclk_valid ? pll_setting : '0;
  wire [F0_DATA_W-1:0] read_view = at_ready ? ready_view :
                                   at_pll ? pll_view :
                                   at_state ? state_view : '0;

  // Everything in this section collapses when the WLAN section resets
  always_ff @(posedge clock) begin
    if (!rst_n || !next_wlan_on) begin
      f0_ready <= 1'b0;
      ref_clock_request <= 1'b0;
      refclk_valid <= 1'b0;
      pll_programmed <= 1'b0;
      pll_setting <= '0;
      link.f0_ack <= 1'b0;
      link.f0_rdata <= '0;
      link.chip_active_irq <= 1'b0;
    end else begin
      link.f0_ack <= f0_take;
      if (f0_take) link.f0_rdata <= read_view;
      if (f0_delay_done) f0_ready <= 1'b1;
      if (wake_write) ref_clock_request <= 1'b1;
      if (refclk_done && ref_clock_request) refclk_valid <= 1'b1;
      if (pll_write) begin
        pll_setting <= link.f0_wdata;
        pll_programmed <= 1'b1;
      end
      // Lock alone is not enough: a stale lock before programming is ignored
      link.chip_active_irq <= pll_programmed & pll_locked;
    end
  end

  // ----------------------------------------------------------------
  // Bluetooth boot and USB attach
  // ----------------------------------------------------------------
  logic boot_done;
  logic bus_reset_seen;

  delay_timer u_boot_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(bt_rise),
    .cycles(TIMER_W'(BOOT_CYCLES)),
    .running(),
    .done(boot_done)
  );

  // Pull-up only after ROM boot; traffic only after reset then a frame start
  always_ff @(posedge clock) begin
    if (!rst_n || !next_bt_on) begin
      link.usb_dp_pullup <= 1'b0;
      bus_reset_seen <= 1'b0;
      bt_link_ready <= 1'b0;
    end else begin
      if (boot_done) link.usb_dp_pullup <= 1'b1;
      if (link.usb_dp_pullup && link.usb_bus_reset) bus_reset_seen <= 1'b1;
      if (bus_reset_seen && !link.usb_bus_reset && link.usb_sof) begin
        bt_link_ready <= 1'b1;
      end
    end
  end

endmodule // wlan_bt_device
`default_nettype wire

// ---- wlan_bt_host.sv ----
// Host end: drives power requests, WLAN handshake and USB attach steps
//
// The address map and the Avalon-MM interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module wlan_bt_host import pwrseq_pkg::*; #(
  parameter int DISCHARGE_WAIT = DISCHARGE_CYCLES,
  parameter int POLL_GAP = POLL_GAP_CYCLES,
  parameter int REF_WAIT = REFCLK_CYCLES,
  parameter int DEBOUNCE_WAIT = DEBOUNCE_CYCLES,
  parameter int BUS_RESET_WAIT = BUS_RESET_CYCLES,
  parameter int SOF_GAP = SOF_GAP_CYCLES,
  parameter logic [F0_DATA_W-1:0] READY_PATTERN = READY_PATTERN_DEFAULT,
  parameter int WAKE_BIT = WAKE_BIT_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  pwrseq_if.host_end link
);
  typedef enum logic [2:0] {W_OFF, W_POLL, W_GAP, W_WAKE, W_REF, W_PLL, W_IRQ, W_ACTIVE} wlan_e;
  typedef enum logic [2:0] {B_OFF, B_ATTACH, B_DEBOUNCE, B_RESET, B_SOF, B_READY} bt_e;

  wlan_e wstate;
  bt_e bstate;
  logic [1:0] ctrl;
  logic [7:0] xtal;
  logic [EVENT_W-1:0] sticky;
  logic [EVENT_W-1:0] mask;
  logic [EVENT_W-1:0] events;
  logic discharging;
  logic w_done;
  logic b_done;

  // ----------------------------------------------------------------
  // Avalon slave: one wait state on every access
  // ----------------------------------------------------------------
  wire rd_done = avs_read & ~avs_waitrequest;
  wire wr_done = avs_write & ~avs_waitrequest;
  wire [EVENT_W-1:0] next_mask = (wr_done && avs_address == REG_MASK) ?
                                 avs_writedata[EVENT_W-1:0] : mask;
  // Hardware set wins over the read clear in the same cycle
  wire [EVENT_W-1:0] next_sticky = ((rd_done && avs_address == REG_STATUS) ?
                                    '0 : sticky) | events;
  wire [31:0] status_view = {21'h0, discharging, bstate != B_OFF, wstate != W_OFF,
                             5'h0, sticky};
  wire [31:0] read_view = avs_address == REG_CTRL ? {30'h0, ctrl} :
                          avs_address == REG_XTAL ? {24'h0, xtal} :
                          avs_address == REG_STATUS ? status_view : {29'h0, mask};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= 32'h0;
      ctrl <= CTRL_RESET;
      xtal <= XTAL_RESET;
      mask <= MASK_RESET;
      sticky <= '0;
      irq <= 1'b0;
    end else begin
      avs_waitrequest <= ~((avs_read | avs_write) & avs_waitrequest);
      if (avs_read && avs_waitrequest) avs_readdata <= read_view;
      if (wr_done && avs_address == REG_CTRL) ctrl <= avs_writedata[1:0];
      if (wr_done && avs_address == REG_XTAL) xtal <= avs_writedata[7:0];
      mask <= next_mask;
      sticky <= next_sticky;
      irq <= |(next_sticky & next_mask);
    end
  end

  // ----------------------------------------------------------------
  // Power requests with regulator discharge hold-off
  // ----------------------------------------------------------------
  wire want_wlan = ctrl[CTRL_WLAN_ON] & ~discharging;
  wire want_bt = ctrl[CTRL_BT_ON] & ~discharging;
  wire discharge_start = (link.wlan_power_request | link.bt_power_request) &
                         ~want_wlan & ~want_bt;

  delay_timer u_discharge (
    .clock(clock),
    .rst_n(rst_n),
    .start(discharge_start),
    .cycles(TIMER_W'(DISCHARGE_WAIT)),
    .running(discharging),
    .done()
  );

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      link.wlan_power_request <= 1'b0;
      link.bt_power_request <= 1'b0;
    end else begin
      link.wlan_power_request <= want_wlan;
      link.bt_power_request <= want_bt;
    end
  end

  // ----------------------------------------------------------------
  // WLAN handshake; every wait may run long without harm
  // ----------------------------------------------------------------
  wire w_access = wstate == W_POLL || wstate == W_WAKE || wstate == W_PLL;
  wire issue = w_access & ~link.f0_req & ~link.f0_ack;
  wire pattern_ok = link.f0_ack && link.f0_rdata == READY_PATTERN;
  wire w_start = (wstate == W_POLL && link.f0_ack && !pattern_ok) ||
                 (wstate == W_WAKE && link.f0_ack);
  wire [TIMER_W-1:0] w_cycles = wstate == W_POLL ? TIMER_W'(POLL_GAP) : TIMER_W'(REF_WAIT);

  delay_timer u_wlan_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(w_start),
    .cycles(w_cycles),
    .running(),
    .done(w_done)
  );

  always_ff @(posedge clock) begin
    if (!rst_n || !link.wlan_power_request) begin
      wstate <= W_OFF;
      link.f0_req <= 1'b0;
      link.f0_write <= 1'b0;
      link.f0_addr <= '0;
      link.f0_wdata <= '0;
    end else begin
      if (link.f0_ack) link.f0_req <= 1'b0;
      else if (issue) begin
        link.f0_req <= 1'b1;
        link.f0_write <= wstate != W_POLL;
        link.f0_addr <= wstate == W_PLL ? F0_PLL_ADDR : F0_READY_ADDR;
        link.f0_wdata <= wstate == W_PLL ? xtal : F0_DATA_W'(1) << WAKE_BIT;
      end
      unique case (wstate)
        W_OFF: wstate <= W_POLL;
        W_POLL: if (link.f0_ack) wstate <= pattern_ok ? W_WAKE : W_GAP;
        W_GAP: if (w_done) wstate <= W_POLL;
        W_WAKE: if (link.f0_ack) wstate <= W_REF;
        W_REF: if (w_done) wstate <= W_PLL;
        W_PLL: if (link.f0_ack) wstate <= W_IRQ;
        W_IRQ: if (link.chip_active_irq) wstate <= W_ACTIVE;
        W_ACTIVE: wstate <= W_ACTIVE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // USB attach: debounce, bus reset, then periodic frame starts
  // ----------------------------------------------------------------
  wire b_start = (bstate == B_ATTACH && link.usb_dp_pullup) ||
                 ((bstate == B_DEBOUNCE || bstate == B_RESET ||
                   bstate == B_SOF || bstate == B_READY) && b_done);
  wire [TIMER_W-1:0] b_cycles = bstate == B_ATTACH ? TIMER_W'(DEBOUNCE_WAIT) :
                                bstate == B_DEBOUNCE ? TIMER_W'(BUS_RESET_WAIT) :
                                TIMER_W'(SOF_GAP);

  delay_timer u_bt_timer (
    .clock(clock),
    .rst_n(rst_n),
    .start(b_start),
    .cycles(b_cycles),
    .running(),
    .done(b_done)
  );

  always_ff @(posedge clock) begin
    if (!rst_n || !link.bt_power_request) begin
      bstate <= B_OFF;
      link.usb_bus_reset <= 1'b0;
      link.usb_sof <= 1'b0;
    end else begin
      link.usb_sof <= 1'b0;
      unique case (bstate)
        B_OFF: bstate <= B_ATTACH;
        B_ATTACH: if (link.usb_dp_pullup) bstate <= B_DEBOUNCE;
        B_DEBOUNCE: if (b_done) begin
          link.usb_bus_reset <= 1'b1;
          bstate <= B_RESET;
        end
        B_RESET: if (b_done) begin
          link.usb_bus_reset <= 1'b0;
          link.usb_sof <= 1'b1;
          bstate <= B_SOF;
        end
        B_SOF, B_READY: if (b_done) begin
          link.usb_sof <= 1'b1;
          bstate <= B_READY;
        end
      endcase
    end
  end

  // One-cycle events feeding the sticky status bits
  always_comb begin
    events = '0;
    events[EV_WLAN_ACTIVE] = wstate == W_IRQ && link.chip_active_irq;
    events[EV_BT_READY] = bstate == B_SOF && b_done;
    events[EV_PATTERN_SEEN] = wstate == W_POLL && pattern_ok;
  end

endmodule // wlan_bt_host
`default_nettype wire

// ---- pwrseq_assertions.sv ----
// Link assertions for the host and device sequencer ends
`timescale 1ns/1ns
`default_nettype none
module pwrseq_assertions (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic wlan_power_request,
  input wire logic bt_power_request,
  input wire logic f0_req,
  input wire logic f0_ack,
  input wire logic [7:0] f0_addr,
  input wire logic chip_active_irq,
  input wire logic usb_dp_pullup,
  input wire logic usb_bus_reset,
  input wire logic usb_sof
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Function-zero handshake: one ack per held request
  a_ack_after_req: assert property (f0_ack |-> $past(f0_req))
    else $error("ack without request");
  a_ack_one_cycle: assert property (f0_ack |=> !f0_ack)
    else $error("ack longer than one cycle");
  a_req_held: assert property (f0_req && !f0_ack |=> f0_req && $stable(f0_addr))
    else $error("request dropped before ack");
  // Lag of two covers the registered reset of the WLAN section
  a_ack_needs_wlan: assert property (f0_ack |-> $past(wlan_power_request, 2))
    else $error("ack while WLAN off");
  a_irq_needs_wlan: assert property ($rose(chip_active_irq) |-> wlan_power_request)
    else $error("active interrupt while WLAN off");
  // USB attach order: boot, debounce, bus reset, frames; then the regulator discharge gap
  a_pullup_after_boot: assert property ($rose(usb_dp_pullup) |-> $past(bt_power_request, 8))
    else $error("pull-up too soon");
  a_debounce_wait: assert property ($rose(usb_bus_reset) |-> $past(usb_dp_pullup, 8))
    else $error("bus reset before debounce");
  a_bus_reset_len: assert property ($fell(usb_bus_reset) && bt_power_request |-> $past(usb_bus_reset, 6))
    else $error("bus reset too short");
  a_sof_pulse: assert property (usb_sof |-> !usb_bus_reset ##1 !usb_sof)
    else $error("frame marker during reset or too long");
  a_discharge_gap: assert property ($fell(wlan_power_request || bt_power_request) |-> !(wlan_power_request || bt_power_request) [*8])
    else $error("request raised during discharge");
endmodule // pwrseq_assertions
`default_nettype wire

// ---- test_wlan_bt_power_up_sequencer.sv ----
// Self-checking bench: host and device ends joined over the link
`timescale 1ns/1ns
`default_nettype none
module test_wlan_bt_power_up_sequencer;
  import pwrseq_pkg::*;
  typedef struct packed {logic [1:0] a; logic [31:0] d; logic [31:0] e;} row_s;
  logic clock = 0;
  logic rst_n, avs_read, avs_write, core_supply_good, io_supply_good, pll_lock;
  logic [1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic avs_waitrequest, irq, regulator_enable, wlan_reset_n, bt_reset_n, por_active;
  logic ref_clock_request, bt_link_ready;
  logic [7:0] pll_setting;
  int fails = 0, compares = 0, cycles = 0, n;
  // Register rows: written value and its expected readback
  row_s rows [4] = '{'{REG_XTAL, 32'h1ff, 32'hff}, '{REG_MASK, 32'hff, 32'h7},
    '{REG_MASK, 32'h5, 32'h5}, '{REG_XTAL, 32'h3c, 32'h3c}};
  always #10 clock = ~clock;
  pwrseq_if link ();
  // Short counts keep the run to a few hundred cycles
  wlan_bt_device #(.POR_HOLD_CYCLES(20), .F0_WAIT_CYCLES(10), .REF_WAIT_CYCLES(15),
    .BOOT_CYCLES(30)) u_wlan_bt_device (.clock, .rst_n, .link, .core_supply_good,
    .io_supply_good, .pll_lock, .regulator_enable, .wlan_reset_n, .bt_reset_n,
    .por_active, .ref_clock_request, .pll_setting, .bt_link_ready);
  wlan_bt_host #(.DISCHARGE_WAIT(25), .POLL_GAP(4), .REF_WAIT(15), .DEBOUNCE_WAIT(12),
    .BUS_RESET_WAIT(6), .SOF_GAP(8)) u_wlan_bt_host (.clock, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .irq, .link);
  pwrseq_assertions u_pwrseq_assertions (.clock, .rst_n,
    .wlan_power_request(link.wlan_power_request), .bt_power_request(link.bt_power_request),
    .f0_req(link.f0_req), .f0_ack(link.f0_ack), .f0_addr(link.f0_addr),
    .chip_active_irq(link.chip_active_irq), .usb_dp_pullup(link.usb_dp_pullup),
    .usb_bus_reset(link.usb_bus_reset), .usb_sof(link.usb_sof));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Avalon access: held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
    @(posedge clock);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  // Counts falling edges until the internal reset lets go; it must end in time
  task automatic por_wait();
    n = 0;
    while (por_active !== 1'b0) begin
      @(negedge clock);
      n++;
    end
    chk(n <= 30, 1);
  endtask
  task automatic wrap_up();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    rst_n <= 1'b0;
    {avs_read, avs_write, pll_lock, avs_address, avs_writedata} <= '0;
    {core_supply_good, io_supply_good} <= 2'b11;
    repeat (4) @(posedge clock);
    chk({avs_waitrequest, por_active, regulator_enable}, 3'b110);
    rst_n <= 1'b1;
    por_wait();
    bus(0, REG_XTAL, 0);
    chk(q, XTAL_RESET);
    bus(0, REG_MASK, 0);
    chk(q, MASK_RESET);
    foreach (rows[i]) begin
      bus(1, rows[i].a, rows[i].d);
      bus(0, rows[i].a, 0);
      chk(q, rows[i].e);
    end
    // WLAN bring-up; lock held back to prove the interrupt waits for it
    bus(1, REG_CTRL, 32'h1);
    repeat (3) @(negedge clock);
    chk({regulator_enable, wlan_reset_n, bt_reset_n}, 3'b110);
    while (ref_clock_request !== 1'b1) @(negedge clock);
    while (pll_setting !== 8'h3c) @(negedge clock);
    repeat (6) @(negedge clock);
    chk(link.chip_active_irq, 0);
    @(posedge clock);
    pll_lock <= 1'b1;
    repeat (10) @(negedge clock);
    chk({link.chip_active_irq, irq}, 2'b11);
    bus(0, REG_STATUS, 0);
    chk(q & 32'h7, 32'h5);
    bus(0, REG_STATUS, 0);
    chk({q[2:0], irq}, 0);
    // Bluetooth attach; its event is masked so the interrupt stays low
    bus(1, REG_CTRL, 32'h3);
    n = 0;
    while (link.usb_dp_pullup !== 1'b1) begin
      @(negedge clock);
      n++;
    end
    chk(n >= 30, 1);
    while (bt_link_ready !== 1'b1) @(negedge clock);
    repeat (12) @(negedge clock);
    chk(irq, 0);
    bus(0, REG_STATUS, 0);
    chk(q & 32'h7, 32'h2);
    // Power-down paths and the discharge hold
    bus(1, REG_CTRL, 32'h2);
    repeat (3) @(negedge clock);
    chk({regulator_enable, wlan_reset_n, bt_reset_n}, 3'b101);
    bus(1, REG_CTRL, 32'h0);
    repeat (3) @(negedge clock);
    chk({regulator_enable, wlan_reset_n, bt_reset_n}, 3'b000);
    bus(1, REG_CTRL, 32'h1);
    bus(0, REG_STATUS, 0);
    chk({q[10], regulator_enable}, 2'b10);
    repeat (30) @(negedge clock);
    chk({regulator_enable, wlan_reset_n}, 2'b11);
    // A supply dip brings the internal reset back and drops the WLAN section
    @(posedge clock);
    io_supply_good <= 1'b0;
    repeat (5) @(negedge clock);
    chk({por_active, wlan_reset_n, regulator_enable}, 3'b101);
    @(posedge clock);
    io_supply_good <= 1'b1;
    por_wait();
    // Reset in mid-run: outputs go back to their reset values and stay there
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (4) @(posedge clock);
    chk({avs_waitrequest, por_active, regulator_enable, wlan_reset_n}, 4'b1100);
    rst_n <= 1'b1;
    repeat (2) @(negedge clock);
    chk({avs_waitrequest, por_active, regulator_enable}, 3'b110);
    por_wait();
    bus(0, REG_MASK, 0);
    chk(q, MASK_RESET);
    wrap_up();
  end
endmodule // test_wlan_bt_power_up_sequencer
`default_nettype wire
